// *** etp_cfg.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: included by bare name; definitions only
// Notes: register numbers are indexes, byte address is four times one
`ifndef ETP_CFG_SVH
`define ETP_CFG_SVH
`define ETP_IDX_POLICY 16'h1c0c
`define ETP_IDX_RATE01 16'h1c0d
`define ETP_IDX_RATE23 16'h1c0e
`define ETP_IDX_BMCFG 16'h1c1f
`define ETP_MASK_POLICY 32'h007f7f7f
`define ETP_MASK_RATE 32'h03ffffff
`define ETP_MASK_BMCFG 32'h00000001
`define ETP_RST_POLICY 32'h00000000
`define ETP_RST_RATE 32'h00000000
`define ETP_RST_BMCFG 32'h00000000
`define ETP_PORT_STRIDE 8
`define ETP_TYPE_LSB 0
`define ETP_CHG_TAG_BIT 2
`define ETP_CHG_PRIO_BIT 3
`define ETP_CHG_VID_BIT 4
`define ETP_INSERT_BIT 5
`define ETP_SELECT_BIT 6
`define ETP_RATE_W 13
`define ETP_RATE_HI_LSB 13
`define ETP_PACE_EN_BIT 0
`define ETP_RATE_STEP_NS 20
`define ETP_CLK_NS 20
`define ETP_STEP_CYC ((`ETP_RATE_STEP_NS + `ETP_CLK_NS - 1) / `ETP_CLK_NS)
`endif

// *** etp_pkg.sv ***
// Purpose: types shared by the egress policy block
// Assumes: nothing
// Notes: codes of the port type field and of the tag actions
package etp_pkg;
   typedef enum logic [1:0] {
      ETP_DUMB = 2'b00,
      ETP_ACCESS = 2'b01,
      ETP_HYBRID = 2'b10,
      ETP_CPU = 2'b11
   } etp_port_type_type;
   typedef enum logic [1:0] {
      ETP_UNTAGGED = 2'b00,
      ETP_PRIO_TAGGED = 2'b01,
      ETP_REG_TAGGED = 2'b10,
      ETP_SPECIAL_TAGGED = 2'b11
   } etp_frame_kind_type;
   typedef enum logic [2:0] {
      ETP_PASS = 3'b000,
      ETP_STRIP = 3'b001,
      ETP_INSERT = 3'b010,
      ETP_REWRITE = 3'b011,
      ETP_ADD_SPECIAL = 3'b100
   } etp_action_type;
   typedef enum logic [1:0] {
      ETP_ST_IDLE = 2'b00,
      ETP_ST_WRITE = 2'b01,
      ETP_ST_READ = 2'b10
   } etp_bus_state_type;
endpackage

// *** etp_if.sv ***
// Purpose: carries register contents from the bank to its users
// Assumes: one clock domain
// Notes: the bank drives, the users only read
`timescale 1ns/1ps
`default_nettype none
interface etp_if;
   logic [31:0] policy;
   logic [31:0] rate01;
   logic [31:0] rate23;
   logic pace_en;
   modport bank (output policy, output rate01, output rate23,
      output pace_en);
   modport user (input policy, input rate01, input rate23, input pace_en);
endinterface
`default_nettype wire

// *** etp_pacer.sv ***
// Purpose: byte pacing of the four port 0 queues
// Assumes: byte_sent is a one-cycle pulse per byte taken
// Notes: a byte sent while not allowed is ignored
`timescale 1ns/1ps
`default_nettype none
`include "etp_cfg.svh"
module etp_pacer
   import etp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   etp_if.user cfg,
   input wire logic [3:0] byte_sent,
   output logic [3:0] may_send
);
   localparam int STEP = `ETP_STEP_CYC;
   logic [7:0] div_reg;
   logic step;
   logic [4*`ETP_RATE_W-1:0] rates;

   assign rates = {cfg.rate23[`ETP_RATE_HI_LSB+`ETP_RATE_W-1:0],
      cfg.rate01[`ETP_RATE_HI_LSB+`ETP_RATE_W-1:0]};
   assign step = (div_reg == 8'(STEP - 1));

   // step pulse every 20 ns worth of cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 8'h00;
      end else if (step) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   genvar q;
   generate
      for (q = 0; q < 4; q++) begin : g_q
         logic [`ETP_RATE_W:0] cnt_reg;
         logic [`ETP_RATE_W:0] cnt_next;
         always_comb begin
            cnt_next = cnt_reg;
            if (!cfg.pace_en) begin
               cnt_next = '0;
            end else if (byte_sent[q] && may_send[q]) begin
               // byte time is value plus one steps
               cnt_next = {1'b0, rates[q*`ETP_RATE_W +: `ETP_RATE_W]}
                  + 14'h0001;
            end else if (step && cnt_reg != '0) begin
               cnt_next = cnt_reg - 14'h0001;
            end
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt_reg <= '0;
               may_send[q] <= 1'b1;
            end else begin
               cnt_reg <= cnt_next;
               may_send[q] <= (cnt_next == '0);
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** etp_tag_decide.sv ***
// Purpose: per-frame egress tag action from the policy register
// Assumes: frame fields are valid together with req
// Notes: answer registered, one cycle after req
`timescale 1ns/1ps
`default_nettype none
`include "etp_cfg.svh"
module etp_tag_decide
   import etp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   etp_if.user cfg,
   input wire logic req,
   input wire logic [1:0] egress_port,
   input wire logic [1:0] kind,
   input wire logic default_untag,
   input wire logic vid_untag,
   output logic done,
   output logic [2:0] action,
   output logic use_egress_default,
   output logic change_vid,
   output logic change_prio
);
   logic [7:0] pf;
   etp_port_type_type ptype;
   etp_frame_kind_type fk;
   etp_action_type act;
   logic cv;
   logic cp;
   logic chg_tag;

   always_comb begin
      pf = 8'h00;
      if (egress_port == 2'd1) begin
         pf = cfg.policy[`ETP_PORT_STRIDE +: 8];
      end else if (egress_port == 2'd2) begin
         pf = cfg.policy[2*`ETP_PORT_STRIDE +: 8];
      end else begin
         pf = cfg.policy[7:0];
      end
   end

   assign ptype = etp_port_type_type'(pf[`ETP_TYPE_LSB +: 2]);
   assign fk = etp_frame_kind_type'(kind);
   assign chg_tag = pf[`ETP_CHG_TAG_BIT];

   always_comb begin
      act = ETP_PASS;
      cv = 1'b0;
      cp = 1'b0;
      case (ptype)
         ETP_DUMB: begin
            if (fk == ETP_SPECIAL_TAGGED) begin
               act = ETP_STRIP;
            end else begin
               act = ETP_PASS;
            end
         end
         ETP_ACCESS: begin
            if (fk != ETP_UNTAGGED) begin
               act = ETP_STRIP;
            end
         end
         ETP_HYBRID: begin
            if (fk == ETP_UNTAGGED) begin
               if (pf[`ETP_INSERT_BIT] && !default_untag) begin
                  act = ETP_INSERT;
               end
            end else if (fk == ETP_SPECIAL_TAGGED || vid_untag) begin
               act = ETP_STRIP;
            end else if (fk == ETP_PRIO_TAGGED) begin
               // change tag has no say over priority tags
               act = ETP_REWRITE;
               cv = 1'b1;
               cp = pf[`ETP_CHG_PRIO_BIT];
            end else if (chg_tag) begin
               cv = pf[`ETP_CHG_VID_BIT];
               cp = pf[`ETP_CHG_PRIO_BIT];
               act = (cv || cp) ? ETP_REWRITE : ETP_PASS;
            end
         end
         default: begin
            act = ETP_ADD_SPECIAL;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
         action <= 3'b000;
         use_egress_default <= 1'b0;
         change_vid <= 1'b0;
         change_prio <= 1'b0;
      end else begin
         done <= req;
         if (req) begin
            action <= act;
            // select only counts for hybrid ports
            use_egress_default <= (ptype == ETP_HYBRID)
               && pf[`ETP_SELECT_BIT];
            change_vid <= cv;
            change_prio <= cp;
         end
      end
   end
endmodule
`default_nettype wire

// *** etp_top.sv ***
// Purpose: egress tag policy and port 0 pacing register bank
// Assumes: AHB-Lite single word transfers, one slave, hclk 50 MHz
// Notes: zero wait states; always OKAY
//
// Notes on behaviour
// - dumb type passes regular port frames unchanged
// - dumb type strips special tags from MII
// - access type strips every tag
// - hybrid type applies per-port tag controls
// - cpu type adds source-port special tag
// - tag controls act only for hybrid
// - change tag gates edits of regular tags
// - change tag ignored for priority tags
// - type fields at 17:16, 9:8, 1:0
// - port 1 controls at bits 14..10
// - port 0 controls at bits 6..2
// - byte time is (value+1) times 20 ns
// - two 13-bit rates, upper bits reserved
// - queues 0/1 then 2/3, consecutive registers
// - pacing needs rates plus config enable
// - select picks ingress or egress defaults
// - insert tags untagged when default not untagged
// - vid rewrite with change tag; always priority
// - priority rewrite; regular needs change tag
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "etp_cfg.svh"
module etp_top
   import etp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic frm_req,
   input wire logic [1:0] frm_egress_port,
   input wire logic [1:0] frm_ingress_port,
   input wire logic [1:0] frm_kind,
   input wire logic frm_default_untag,
   input wire logic frm_vid_untag,
   output logic dec_valid,
   output logic [2:0] dec_action,
   output logic [1:0] dec_src_port,
   output logic dec_use_egress_default,
   output logic dec_change_vid,
   output logic dec_change_prio,
   input wire logic [3:0] q_byte_sent,
   output logic [3:0] q_may_send
);
   etp_if regs ();

   logic [31:0] policy_reg;
   logic [31:0] rate01_reg;
   logic [31:0] rate23_reg;
   logic [31:0] bmcfg_reg;
   etp_bus_state_type state_reg;
   logic [1:0] sel_reg;
   logic [1:0] sel_next;
   logic [31:0] rdata_next;
   logic take;
   logic [1:0] src_reg;

   // decode used by both the address and the data phase
   function automatic logic [1:0] reg_index(input logic [31:0] a);
      logic [1:0] r;
      r = 2'b00;
      if (a == {14'h0000, `ETP_IDX_POLICY, 2'b00}) begin
         r = 2'd0;
      end else if (a == {14'h0000, `ETP_IDX_RATE01, 2'b00}) begin
         r = 2'd1;
      end else if (a == {14'h0000, `ETP_IDX_RATE23, 2'b00}) begin
         r = 2'd2;
      end else if (a == {14'h0000, `ETP_IDX_BMCFG, 2'b00}) begin
         r = 2'd3;
      end
      return r;
   endfunction

   function automatic logic is_mapped(input logic [31:0] a);
      logic m;
      m = 1'b0;
      if (a == {14'h0000, `ETP_IDX_POLICY, 2'b00}) begin
         m = 1'b1;
      end else if (a == {14'h0000, `ETP_IDX_RATE01, 2'b00}) begin
         m = 1'b1;
      end else if (a == {14'h0000, `ETP_IDX_RATE23, 2'b00}) begin
         m = 1'b1;
      end else if (a == {14'h0000, `ETP_IDX_BMCFG, 2'b00}) begin
         m = 1'b1;
      end
      return m;
   endfunction

   // only whole words to a known register are taken
   assign take = hsel && htrans[1] && hready && hsize == 3'b010
      && is_mapped(haddr);
   assign sel_next = reg_index(haddr);

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ETP_ST_IDLE;
         sel_reg <= 2'b00;
      end else if (hready) begin
         if (take && hwrite) begin
            state_reg <= ETP_ST_WRITE;
         end else if (take) begin
            state_reg <= ETP_ST_READ;
         end else begin
            state_reg <= ETP_ST_IDLE;
         end
         sel_reg <= sel_next;
      end
   end

   // write commit in the data phase, reserved bits masked off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         policy_reg <= `ETP_RST_POLICY;
         rate01_reg <= `ETP_RST_RATE;
         rate23_reg <= `ETP_RST_RATE;
         bmcfg_reg <= `ETP_RST_BMCFG;
      end else if (state_reg == ETP_ST_WRITE) begin
         case (sel_reg)
            2'd0: begin
               policy_reg <= hwdata & `ETP_MASK_POLICY;
            end
            2'd1: begin
               rate01_reg <= hwdata & `ETP_MASK_RATE;
            end
            2'd2: begin
               rate23_reg <= hwdata & `ETP_MASK_RATE;
            end
            default: begin
               bmcfg_reg <= hwdata & `ETP_MASK_BMCFG;
            end
         endcase
      end
   end

   // read data is prepared in the address phase so hrdata is a flop;
   // a write in flight to the same word is forwarded so that a read
   // straight after it never returns the old value
   always_comb begin
      rdata_next = 32'h00000000;
      if (state_reg == ETP_ST_WRITE && sel_reg == sel_next) begin
         case (sel_next)
            2'd0: rdata_next = hwdata & `ETP_MASK_POLICY;
            2'd1: rdata_next = hwdata & `ETP_MASK_RATE;
            2'd2: rdata_next = hwdata & `ETP_MASK_RATE;
            default: rdata_next = hwdata & `ETP_MASK_BMCFG;
         endcase
      end else begin
         case (sel_next)
            2'd0: rdata_next = policy_reg;
            2'd1: rdata_next = rate01_reg;
            2'd2: rdata_next = rate23_reg;
            default: rdata_next = bmcfg_reg;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (take && !hwrite) begin
         hrdata <= rdata_next;
      end else if (hready) begin
         // unmapped or idle: data reads as zero
         hrdata <= 32'h00000000;
      end
   end

   // never stalls, never errors
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign regs.policy = policy_reg;
   assign regs.rate01 = rate01_reg;
   assign regs.rate23 = rate23_reg;
   assign regs.pace_en = bmcfg_reg[`ETP_PACE_EN_BIT];

   // source port tagged along with the decision for cpu type
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_reg <= 2'b00;
      end else if (frm_req) begin
         src_reg <= frm_ingress_port;
      end
   end
   assign dec_src_port = src_reg;

   etp_tag_decide u_decide (
      .clk(hclk),
      .rst_n(hresetn),
      .cfg(regs),
      .req(frm_req),
      .egress_port(frm_egress_port),
      .kind(frm_kind),
      .default_untag(frm_default_untag),
      .vid_untag(frm_vid_untag),
      .done(dec_valid),
      .action(dec_action),
      .use_egress_default(dec_use_egress_default),
      .change_vid(dec_change_vid),
      .change_prio(dec_change_prio)
   );

   etp_pacer u_pacer (
      .clk(hclk),
      .rst_n(hresetn),
      .cfg(regs),
      .byte_sent(q_byte_sent),
      .may_send(q_may_send)
   );
endmodule
`default_nettype wire

// *** etp_top_properties.sv ***
// Purpose: port-level checks of the egress policy bank
// Assumes: one clock, reset low and asynchronous
// Notes: pacing enable is not visible here, so only fall causes are checked
`timescale 1ns/1ps
`default_nettype none
module etp_top_properties
   import etp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic [31:0] hrdata,
   input wire logic frm_req,
   input wire logic [1:0] frm_ingress_port,
   input wire logic dec_valid,
   input wire logic [2:0] dec_action,
   input wire logic [1:0] dec_src_port,
   input wire logic dec_use_egress_default,
   input wire logic [3:0] q_byte_sent,
   input wire logic [3:0] q_may_send
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   dec_pulse_a: assert property (frm_req |=> dec_valid)
      else $error("no decision after request");
   dec_quiet_a: assert property (!frm_req |=> !dec_valid)
      else $error("decision without request");
   src_echo_a: assert property (frm_req |=>
      dec_src_port == $past(frm_ingress_port))
      else $error("source port not echoed");
   action_hold_a: assert property (!frm_req |=> $stable(dec_action))
      else $error("action changed without request");
   cpu_no_sel_a: assert property (dec_valid && dec_action == 3'h4
      |-> !dec_use_egress_default)
      else $error("select used outside hybrid");
   rsvd_read_a: assert property (hrdata[31:26] == 6'h0)
      else $error("reserved read bits set");
   idle_read_a: assert property (!(hsel && htrans[1]) |=> hrdata == 32'h0)
      else $error("read data without read");
   fall_cause_a: assert property
      (($past(q_may_send) & ~q_may_send & ~$past(q_byte_sent)) == 4'h0)
      else $error("queue blocked without a byte");
   cover property (dec_valid && dec_action == 3'h4);
   cover property (dec_valid && dec_action == 3'h3);
   cover property ($fell(q_may_send[0]));
endmodule
bind etp_top etp_top_properties u_props (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hrdata(hrdata), .frm_req(frm_req),
   .frm_ingress_port(frm_ingress_port), .dec_valid(dec_valid),
   .dec_action(dec_action), .dec_src_port(dec_src_port),
   .dec_use_egress_default(dec_use_egress_default),
   .q_byte_sent(q_byte_sent), .q_may_send(q_may_send));
`default_nettype wire

// *** etp_egress_model.sv ***
// Purpose: egress datapath stand-in taking bytes from the four queues
// Assumes: stall comes from the bench
// Notes: offers a byte one cycle after seeing the queue allowed
`timescale 1ns/1ps
`default_nettype none
module etp_egress_model
   import etp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] stall,
   input wire logic [3:0] q_may_send,
   output logic [3:0] q_byte_sent
);
   // lagging by one cycle also offers bytes while blocked, which must be ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q_byte_sent <= 4'h0;
      end else begin
         q_byte_sent <= q_may_send & ~stall;
      end
   end
endmodule
`default_nettype wire

// *** etp_top_tb.sv ***
// Purpose: self-checking bench of the egress policy bank
// Assumes: zero wait state slave, seed fixed
// Notes: decisions sweep every type, kind and port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   error_cnt++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module etp_top_tb
   import etp_pkg::*;
;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, frm_req = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = '0, frm_egress_port = '0, frm_ingress_port = '0;
   logic [2:0] hsize = '0, dec_action;
   logic [1:0] frm_kind = '0, dec_src_port;
   logic frm_default_untag = 0, frm_vid_untag = 0, hreadyout, hresp;
   logic dec_valid, dec_use_egress_default, dec_change_vid, dec_change_prio;
   logic [3:0] q_byte_sent, q_may_send, stall = '0;
   int error_cnt = 0, total_checks = 0, nrise = 0, low[4], v[4];
   logic [2:0] wsize = 3'h2;
   logic paced_on = 1;
   etp_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .frm_req(frm_req), .frm_egress_port(frm_egress_port),
      .frm_ingress_port(frm_ingress_port), .frm_kind(frm_kind),
      .frm_default_untag(frm_default_untag), .frm_vid_untag(frm_vid_untag),
      .dec_valid(dec_valid), .dec_action(dec_action),
      .dec_src_port(dec_src_port),
      .dec_use_egress_default(dec_use_egress_default),
      .dec_change_vid(dec_change_vid), .dec_change_prio(dec_change_prio),
      .q_byte_sent(q_byte_sent), .q_may_send(q_may_send));
   etp_egress_model u_far (.hclk(hclk), .hresetn(hresetn), .stall(stall),
      .q_may_send(q_may_send), .q_byte_sent(q_byte_sent));
   always #10 hclk = ~hclk;
   always @(posedge hclk) stall <= 4'($urandom);
   task automatic report_and_stop();
      $display("errors %0d checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // waits on hready without assuming a latency
   task automatic xfer(input logic w, input logic [31:0] a, d,
      output logic [31:0] r);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= wsize;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
      `CHK("resp", 1'b0, hresp)
   endtask
   function automatic logic [2:0] exp_act(logic [1:0] t, logic [6:0] c,
      logic [1:0] k, logic du, logic vu);
      if (t == 2'h0) return (k == 2'h3) ? 3'h1 : 3'h0;
      if (t == 2'h1) return (k == 2'h0) ? 3'h0 : 3'h1;
      if (t == 2'h3) return 3'h4;
      if (k == 2'h3 || (k != 2'h0 && vu)) return 3'h1;
      if (k == 2'h0) return (c[5] && !du) ? 3'h2 : 3'h0;
      if (k == 2'h1) return 3'h3;
      return (c[2] && (c[3] || c[4])) ? 3'h3 : 3'h0;
   endfunction
   // a rise ends one byte time, counted in low cycles
   always @(posedge hclk) begin
      for (int q = 0; q < 4; q++) begin
         if (q_may_send[q] === 1'b0) begin
            low[q]++;
         end else if (low[q] != 0) begin
            if (paced_on)
               `CHK("byte time", v[q] + 1, low[q])
            low[q] = 0;
            nrise++;
         end
      end
   end
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      logic [31:0] r, d, pol, adr[4], msk[3];
      logic [1:0] t, k, p;
      logic [6:0] c;
      logic [2:0] ea;
      adr = '{32'h7030, 32'h7034, 32'h7038, 32'h707c};
      msk = '{32'h007f7f7f, 32'h03ffffff, 32'h03ffffff};
      void'($urandom(66));
      repeat (4) @(posedge hclk);
      hresetn <= 1;
      for (int i = 0; i < 5; i++) begin
         xfer(0, (i < 4) ? adr[i] : 32'h7040, '0, r);
         `CHK("reset", 32'h0, r)
      end
      // a narrow write must be refused
      wsize = 3'h0;
      xfer(1, adr[0], 32'hffffffff, r);
      wsize = 3'h2;
      xfer(0, adr[0], '0, r);
      `CHK("narrow", 32'h0, r)
      for (int i = 0; i < 8; i++) begin
         d = (i < 3) ? 32'hffffffff : $urandom;
         xfer(1, adr[i % 3], d, r);
         xfer(0, adr[i % 3], '0, r);
         `CHK("readback", d & msk[i % 3], r)
      end
      xfer(1, 32'h7040, 32'hffffffff, r);
      xfer(0, 32'h7040, '0, r);
      `CHK("unmapped", 32'h0, r)
      // read issued in the data phase of a write must see the new word
      hwrite <= 1;
      haddr <= adr[1];
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hwdata <= 32'h0000abcd;
      hwrite <= 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      `CHK("forward", 32'h0000abcd, hrdata)
      for (int i = 0; i < 48; i++) begin
         t = 2'(i % 4);
         k = 2'(i / 4);
         p = 2'(i / 16);
         pol = ($urandom & ~(32'h3 << (p * 8))) | (32'(t) << (p * 8));
         c = 7'(pol >> (p * 8));
         xfer(1, adr[0], pol, r);
         frm_req <= 1;
         frm_egress_port <= p;
         frm_ingress_port <= 2'($urandom % 3);
         frm_kind <= k;
         frm_default_untag <= 1'($urandom);
         frm_vid_untag <= (k != 2'h0) && 1'($urandom);
         @(posedge hclk);
         frm_req <= 0;
         @(posedge hclk);
         ea = exp_act(t, c, k, frm_default_untag, frm_vid_untag);
         `CHK("valid", 1'b1, dec_valid)
         `CHK("action", ea, dec_action)
         `CHK("source", frm_ingress_port, dec_src_port)
         if (t != 2'h2 || ea == 3'h2 || ea == 3'h3)
            `CHK("select", t == 2'h2 && c[6], dec_use_egress_default)
         if (ea == 3'h3) begin
            `CHK("vid", k == 2'h1 || c[4], dec_change_vid)
            `CHK("prio", c[3], dec_change_prio)
         end
      end
      repeat (20) @(posedge hclk);
      `CHK("unpaced", 4'hf, q_may_send)
      for (int q = 0; q < 4; q++) v[q] = (q == 0) ? 0 : $urandom % 6;
      xfer(1, adr[1], (32'(v[1]) << 13) | 32'(v[0]), r);
      xfer(1, adr[2], (32'(v[3]) << 13) | 32'(v[2]), r);
      xfer(1, adr[3], 32'h1, r);
      xfer(0, adr[3], '0, r);
      `CHK("enable", 32'h1, r)
      repeat (300) @(posedge hclk);
      `CHK("paced", 1'b1, nrise > 20)
      // clearing the enable frees every queue at once
      paced_on = 0;
      xfer(1, adr[3], 32'h0, r);
      repeat (2) @(posedge hclk);
      `CHK("disabled", 4'hf, q_may_send)
      report_and_stop();
   end
endmodule
`default_nettype wire
